//--- low_power_clock_loss_handler.sv
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`include "lp_defines.svh"
// Functional notes
// - Monitoring off: an oscillator failure in wait causes nothing.
// - Monitoring on, fallback off: failure in wait gives an immediate monitor reset.
// - Fallback on, interrupt masked: stay waiting, PLL/regulator on, fallback, check, flag.
// - Clock good 4096 oscillator cycles after failure ends; leave fallback, PLL per setting.
// - The regulator is never put in low power while waiting.
// - After recovery, wake or external reset exits wait on the oscillator clock.
// - Without recovery, checks repeat indefinitely and only wake or external reset leaves wait.
// - Wake while clock missing exits wait in fallback on minimum VCO clock.
// - External reset while clock missing exits in fallback, starts reset, keeps checking.
// - Interrupt enabled: failure in wait sets flag and wakes the core in fallback.
// - Stop switches the oscillator off unless pseudo-stop is selected.
// - Counters and dividers are frozen, not cleared, during stop.
// - Pseudo-stop keeps timer and watchdog running when their keep bits are set.
// - Entering stop requests low-power mode from other units such as the regulator.
// - Stop entry: clear PLL select, PLL off, core clock off, system clocks off.
// - Pseudo-stop from fallback keeps checking with PLL and regulator on.
// - Full stop from fallback aborts the check; a new one starts on exit.
// - Fallback derives bus and core clocks from the minimum-frequency VCO.
// - PLL off in wait leaves PLL select cleared after wake; software resets it.
module low_power_clock_loss_handler import lp_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic core_wait_req,
	input wire logic core_stop_req,
	input wire logic wake_irq,
	input wire logic ext_reset_pin,
	input wire logic clock_monitor_fail,
	input wire logic oscillator_clock,
	output power_ctl_s power_ctl,
	output logic self_clock_wakeup_irq,
	output logic monitor_reset,
	output logic reset_seq_start,
	output logic core_wake
);

	// ------------------------------------------------------------------------
	// Input synchronisation and edge detection
	// ------------------------------------------------------------------------
	logic [`LP_SYNC_W-1:0] sync_w;
	logic s_osc, s_fail, s_ext;
	logic osc_q_r, fail_q_r, ext_q_r;
	logic osc_edge, fail_evt, ext_evt, qc_good;

	lp_sync2 u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in({ext_reset_pin, clock_monitor_fail, oscillator_clock}),
		.sync_out(sync_w)
	);

	assign s_osc = sync_w[0];
	assign s_fail = sync_w[1];
	assign s_ext = sync_w[2];
	assign osc_edge = s_osc & ~osc_q_r;
	assign fail_evt = s_fail & ~fail_q_r;
	assign ext_evt = s_ext & ~ext_q_r;

	// Edge history flops read only the synchronised copies.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_q_r <= 1'b0;
			fail_q_r <= 1'b0;
			ext_q_r <= 1'b0;
		end else begin
			osc_q_r <= s_osc;
			fail_q_r <= s_fail;
			ext_q_r <= s_ext;
		end
	end

	// ------------------------------------------------------------------------
	// AHB-Lite slave
	// ------------------------------------------------------------------------
	ctrl_s ctrl_r, ctrl_nxt;
	logic flag_r, flag_nxt;
	logic scm_r, scm_nxt;
	logic good_seen_r, good_seen_nxt;
	lp_state_e state_r, state_nxt;
	logic wr_pend_r, wr_pend_nxt;
	logic [`LP_ADDR_MSB:0] wr_addr_r, wr_addr_nxt;
	logic [31:0] hrdata_nxt;
	logic wr_ctrl, wr_status, addr_ok;

	// Decoding shared by the read mux and the write capture.
	function automatic logic [1:0] reg_sel(input logic [`LP_ADDR_MSB:0] a);
		reg_sel = 2'b00;
		if (a == (`LP_ADDR_MSB+1)'(`LP_CTRL_OFS)) reg_sel = 2'b01;
		if (a == (`LP_ADDR_MSB+1)'(`LP_STATUS_OFS)) reg_sel = 2'b10;
	endfunction

	assign addr_ok = hsel && hready && htrans[1];
	assign wr_ctrl = wr_pend_r && (reg_sel(wr_addr_r) == 2'b01);
	assign wr_status = wr_pend_r && (reg_sel(wr_addr_r) == 2'b10);

	// Zero wait states; read data is sampled in the address phase for the next.
	always_comb begin
		wr_pend_nxt = addr_ok && hwrite;
		wr_addr_nxt = haddr[`LP_ADDR_MSB:0];
		hrdata_nxt = hrdata;
		if (addr_ok && !hwrite) begin
			case (reg_sel(haddr[`LP_ADDR_MSB:0]))
				2'b01: hrdata_nxt = {24'h000000, ctrl_r};
				2'b10: hrdata_nxt = {25'h0000000, state_r, 1'b0, good_seen_r, scm_r, flag_r};
				default: hrdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			hrdata <= hrdata_nxt;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------------
	logic qc_restart_r, qc_restart_nxt, qc_run;
	logic mon_rst_nxt, rst_seq_nxt, wake_nxt, pll_on_r, pll_on_nxt;
	logic in_stop, full_stop;
	power_ctl_s pwr_nxt;

	assign in_stop = (state_r != ST_RUN) && (state_r != ST_WAIT);
	assign full_stop = in_stop && !ctrl_r.pseudo_stop_select;
	assign qc_run = scm_r && !full_stop;

	lp_quality_check u_qc (
		.hclk(hclk),
		.hresetn(hresetn),
		.osc_edge(osc_edge),
		.monitor_fail(s_fail),
		.run(qc_run),
		.restart(qc_restart_r),
		.clock_good(qc_good)
	);

	// Mode decisions; software writes land first so hardware clears win over them.
	always_comb begin
		state_nxt = state_r;
		ctrl_nxt = ctrl_r;
		scm_nxt = scm_r;
		pll_on_nxt = pll_on_r;
		good_seen_nxt = good_seen_r | qc_good;
		qc_restart_nxt = 1'b0;
		mon_rst_nxt = 1'b0;
		rst_seq_nxt = 1'b0;
		wake_nxt = 1'b0;
		if (wr_ctrl) ctrl_nxt = hwdata[`LP_CTRL_W-1:0];
		// The flag is sticky; a new event in the clearing cycle wins.
		flag_nxt = flag_r & ~(wr_status & hwdata[`LP_FLAG_BIT]);
		if (qc_good) begin
			scm_nxt = 1'b0;
			if (state_r == ST_WAIT) pll_on_nxt = !ctrl_r.pll_off_in_wait;
		end
		case (state_r)
			ST_RUN: begin
				if (core_stop_req) begin
					state_nxt = ST_STOP_SEL;
				end else if (core_wait_req) begin
					state_nxt = ST_WAIT;
					if (ctrl_r.pll_off_in_wait && !scm_r) begin
						ctrl_nxt.pll_clock_select = 1'b0;
						pll_on_nxt = 1'b0;
					end
				end
			end
			ST_WAIT: begin
				// Without a wake source the sequencer stays here, checks repeating.
				if (ext_evt) begin
					state_nxt = ST_RUN;
					rst_seq_nxt = 1'b1;
					pll_on_nxt = 1'b1;
				end else if (wake_irq) begin
					state_nxt = ST_RUN;
					wake_nxt = 1'b1;
					pll_on_nxt = 1'b1;
				end
			end
			ST_STOP_SEL: begin
				ctrl_nxt.pll_clock_select = 1'b0;
				state_nxt = ST_STOP_PLL;
			end
			ST_STOP_PLL: begin
				pll_on_nxt = scm_r && ctrl_r.pseudo_stop_select;
				state_nxt = ST_STOP_CORE;
			end
			ST_STOP_CORE: state_nxt = ST_STOP_SYS;
			ST_STOP_SYS: state_nxt = ST_STOP;
			ST_STOP: begin
				if (ext_evt || wake_irq) begin
					state_nxt = ST_RUN;
					rst_seq_nxt = ext_evt;
					wake_nxt = !ext_evt;
					pll_on_nxt = 1'b1;
					qc_restart_nxt = scm_r && !ctrl_r.pseudo_stop_select;
				end
			end
			default: state_nxt = ST_RUN;
		endcase
		// A failure outside stop is handled by the monitor settings.
		if (fail_evt && ctrl_r.clock_monitor_enable && !in_stop) begin
			if (!ctrl_r.self_clock_fallback_enable) begin
				mon_rst_nxt = 1'b1;
				state_nxt = ST_RUN;
				pll_on_nxt = 1'b1;
			end else begin
				scm_nxt = 1'b1;
				flag_nxt = 1'b1;
				pll_on_nxt = 1'b1;
				qc_restart_nxt = 1'b1;
				ctrl_nxt.pll_clock_select = 1'b0;
				if (state_r == ST_WAIT && ctrl_r.self_clock_interrupt_enable) begin
					state_nxt = ST_RUN;
					wake_nxt = 1'b1;
				end
			end
		end
	end

	// Chip-level controls follow the next state so they change with it.
	always_comb begin
		pwr_nxt.pll_enable = pll_on_nxt;
		// The PLL drops leaving the PLL step, the core one step later, the system last.
		pwr_nxt.core_clock_enable = (state_nxt != ST_STOP_SYS) && (state_nxt != ST_STOP);
		pwr_nxt.system_clock_enable = (state_nxt != ST_STOP);
		pwr_nxt.oscillator_enable = !(state_nxt == ST_STOP && !ctrl_nxt.pseudo_stop_select);
		// Regulator low power only in stop, and not while a pseudo-stop check runs.
		pwr_nxt.regulator_low_power = (state_nxt == ST_STOP)
			&& !(scm_nxt && ctrl_nxt.pseudo_stop_select);
		pwr_nxt.counters_freeze = (state_nxt == ST_STOP);
		pwr_nxt.periodic_timer_run = (state_nxt != ST_STOP)
			|| (ctrl_nxt.pseudo_stop_select && ctrl_nxt.timer_keep_running);
		pwr_nxt.watchdog_run = (state_nxt != ST_STOP)
			|| (ctrl_nxt.pseudo_stop_select && ctrl_nxt.watchdog_keep_running);
		if (scm_nxt) pwr_nxt.clock_source = SRC_VCO_MIN;
		else if (ctrl_nxt.pll_clock_select) pwr_nxt.clock_source = SRC_PLL;
		else pwr_nxt.clock_source = SRC_OSC;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= ST_RUN;
			ctrl_r <= `LP_CTRL_RESET;
			flag_r <= 1'b0;
			scm_r <= 1'b0;
			good_seen_r <= 1'b0;
			pll_on_r <= 1'b1;
			qc_restart_r <= 1'b0;
			power_ctl <= '{SRC_OSC, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
			self_clock_wakeup_irq <= 1'b0;
			monitor_reset <= 1'b0;
			reset_seq_start <= 1'b0;
			core_wake <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ctrl_r <= ctrl_nxt;
			flag_r <= flag_nxt;
			scm_r <= scm_nxt;
			good_seen_r <= good_seen_nxt;
			pll_on_r <= pll_on_nxt;
			qc_restart_r <= qc_restart_nxt;
			power_ctl <= pwr_nxt;
			self_clock_wakeup_irq <= flag_nxt && ctrl_nxt.self_clock_interrupt_enable;
			monitor_reset <= mon_rst_nxt;
			reset_seq_start <= rst_seq_nxt;
			core_wake <= wake_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic wait_fail;
	assign wait_fail = (state_r == ST_WAIT) && fail_evt && ctrl_r.clock_monitor_enable;

	sequence stop_walk;
		(state_r == ST_STOP_SEL) ##1 (state_r == ST_STOP_PLL && !ctrl_r.pll_clock_select)
			##1 (state_r == ST_STOP_CORE && power_ctl.core_clock_enable)
			##1 (state_r == ST_STOP_SYS && !power_ctl.core_clock_enable && power_ctl.system_clock_enable)
			##1 (state_r == ST_STOP && !power_ctl.system_clock_enable);
	endsequence

	a_no_detect: assert property ((state_r == ST_WAIT) && fail_evt && !ctrl_r.clock_monitor_enable
		|=> !monitor_reset && !$rose(scm_r) && !$rose(flag_r)) else $error("undetected loss acted");
	a_monitor_reset: assert property (wait_fail && !ctrl_r.self_clock_fallback_enable
		|=> monitor_reset && state_r == ST_RUN) else $error("no monitor reset");
	a_masked_wait: assert property (wait_fail && ctrl_r.self_clock_fallback_enable
		&& !ctrl_r.self_clock_interrupt_enable && !wake_irq && !ext_evt
		|=> state_r == ST_WAIT && scm_r && flag_r && pll_on_r && !core_wake) else $error("masked fallback wrong");
	a_good_leave: assert property (qc_good |=> !scm_r) else $error("fallback kept after good");
	a_wait_voltage_regulator: assert property (state_r == ST_WAIT |-> !power_ctl.regulator_low_power) else $error("regulator low in wait");
	a_irq_wake: assert property (wait_fail && ctrl_r.self_clock_fallback_enable
		&& ctrl_r.self_clock_interrupt_enable |=> state_r == ST_RUN && core_wake && scm_r) else $error("no fallback wake");
	a_osc_stop: assert property (state_r == ST_STOP && !ctrl_r.pseudo_stop_select
		|-> !power_ctl.oscillator_enable) else $error("oscillator on in stop");
	a_stop_order: assert property (state_r == ST_RUN && core_stop_req |=> stop_walk) else $error("stop entry order");
	a_scm_source: assert property (scm_r |-> power_ctl.clock_source == SRC_VCO_MIN) else $error("fallback source wrong");
	a_flag_sticky: assert property (flag_r && !(wr_status && hwdata[`LP_FLAG_BIT]) |=> flag_r) else $error("flag dropped");

endmodule

//--- low_power_clock_loss_handler_bench.sv
`include "lp_defines.svh"
module low_power_clock_loss_handler_bench import lp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Harness
	// ----
	localparam logic [31:0] CA = `LP_CTRL_OFS;
	localparam logic [31:0] SA = `LP_STATUS_OFS;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic osc = 1'b0, osc_run = 1'b1, fail = 1'b0;
	logic [3:0] cmd = 4'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, irq, mr, rss, cw, wreq, sreq, wirq, xrst;
	logic seen_mr, seen_cw, seen_rs;
	power_ctl_s pc;
	int error_cnt = 0;
	int n_checks = 0;
	// A 4 ns bus clock and a 50 MHz oscillator that stands still while lost.
	always #2 hclk = ~hclk;
	always #10 osc = osc_run ? ~osc : osc;
	low_power_clock_loss_handler dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core_wait_req(wreq),
		.core_stop_req(sreq), .wake_irq(wirq), .ext_reset_pin(xrst), .clock_monitor_fail(fail),
		.oscillator_clock(osc), .power_ctl(pc), .self_clock_wakeup_irq(irq), .monitor_reset(mr),
		.reset_seq_start(rss), .core_wake(cw));
	lp_core_model core (.hclk(hclk), .hresetn(hresetn), .cmd(cmd), .core_wake(cw),
		.reset_seq_start(rss), .monitor_reset(mr), .core_wait_req(wreq), .core_stop_req(sreq),
		.wake_irq(wirq), .ext_reset_pin(xrst));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One single AHB-Lite transfer; each phase is held until hready, only the watchdog ends a hang.
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wrr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdm(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q & m, e);
	endtask
	task automatic pulse(input logic [3:0] c);
		@(posedge hclk);
		cmd <= c;
		@(posedge hclk);
		cmd <= 4'h0;
	endtask
	// Pulses stand one cycle, so every edge of the span is inspected.
	task automatic watch(input int n);
		seen_mr = 1'b0;
		seen_cw = 1'b0;
		seen_rs = 1'b0;
		repeat (n) begin
			@(posedge hclk);
			seen_mr |= (mr === 1'b1);
			seen_cw |= (cw === 1'b1);
			seen_rs |= (rss === 1'b1);
		end
	endtask
	task automatic lose();
		@(posedge hclk);
		osc_run <= 1'b0;
		fail <= 1'b1;
	endtask
	task automatic regain();
		@(posedge hclk);
		osc_run <= 1'b1;
		fail <= 1'b0;
	endtask
	task automatic fb_wait(output int n);
		n = 0;
		while (pc.clock_source === SRC_VCO_MIN && n < 30000) begin
			@(posedge hclk);
			n++;
		end
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		rdm(CA, 32'hFFFFFFFF, 32'h00000003);
		rdm(SA, 32'hFFFFFFFF, 32'h00000000);
		rdm(32'h00000008, 32'hFFFFFFFF, 32'h00000000);
		chk({22'h0, pc}, 32'h000000F3);
		chk(hresp, 1'b0);
		$display("t_reset done");
	endtask
	task automatic t_mon_off();
		wrr(CA, 32'h00000000);
		pulse(4'h1);
		watch(3);
		lose();
		watch(20);
		chk(seen_mr, 1'b0);
		chk(seen_cw, 1'b0);
		rdm(SA, 32'h00000073, 32'h00000010);
		regain();
		pulse(4'h4);
		watch(6);
		chk(seen_cw, 1'b1);
		$display("t_mon_off done");
	endtask
	task automatic t_mon_rst();
		wrr(CA, 32'h00000001);
		pulse(4'h1);
		watch(3);
		lose();
		watch(6);
		chk(seen_mr, 1'b1);
		rdm(SA, 32'h00000070, 32'h00000000);
		regain();
		watch(6);
		$display("t_mon_rst done");
	endtask
	task automatic t_masked();
		int n;
		wrr(CA, 32'h0000008B);
		pulse(4'h1);
		watch(3);
		rdm(CA, 32'h00000080, 32'h00000000);
		lose();
		watch(12);
		chk(seen_cw, 1'b0);
		chk(irq, 1'b0);
		rdm(SA, 32'h00000073, 32'h00000013);
		chk(pc.clock_source, SRC_VCO_MIN);
		chk(pc.pll_enable, 1'b1);
		chk(pc.regulator_low_power, 1'b0);
		regain();
		fb_wait(n);
		chk(n >= 20470 && n <= 20560, 1'b1);
		rdm(SA, 32'h00000073, 32'h00000011);
		chk(pc.clock_source, SRC_OSC);
		chk(pc.pll_enable, 1'b0);
		chk(pc.regulator_low_power, 1'b0);
		pulse(4'h4);
		watch(4);
		chk(seen_cw, 1'b1);
		chk(pc.clock_source, SRC_OSC);
		rdm(CA, 32'h00000080, 32'h00000000);
		wrr(CA, 32'h0000008B);
		rdm(CA, 32'h00000080, 32'h00000080);
		wrr(SA, 32'h00000001);
		rdm(SA, 32'h00000001, 32'h00000000);
		$display("t_masked done");
	endtask
	// Stop entry is watched edge by edge to pin down the order of the steps.
	task automatic t_stop();
		int tq, tp, tc, ts;
		tq = 0;
		tp = 0;
		tc = 0;
		ts = 0;
		chk(pc.clock_source, SRC_PLL);
		pulse(4'h2);
		for (int i = 1; i <= 10; i++) begin
			@(posedge hclk);
			if (tq == 0 && pc.clock_source === SRC_OSC) tq = i;
			if (tp == 0 && pc.pll_enable === 1'b0) tp = i;
			if (tc == 0 && pc.core_clock_enable === 1'b0) tc = i;
			if (ts == 0 && pc.system_clock_enable === 1'b0) ts = i;
		end
		chk(tq > 0, 1'b1);
		chk(tp - tq, 32'h1);
		chk(tc - tp, 32'h1);
		chk(ts - tc, 32'h1);
		rdm(SA, 32'h00000070, 32'h00000060);
		rdm(CA, 32'h00000080, 32'h00000000);
		chk(pc.oscillator_enable, 1'b0);
		chk(pc.regulator_low_power, 1'b1);
		chk(pc.counters_freeze, 1'b1);
		pulse(4'h4);
		watch(4);
		chk(seen_cw, 1'b1);
		chk(pc.counters_freeze, 1'b0);
		$display("t_stop done");
	endtask
	task automatic t_fb_wake();
		wrr(CA, 32'h00000007);
		pulse(4'h1);
		watch(3);
		lose();
		watch(12);
		chk(seen_cw, 1'b1);
		chk(irq, 1'b1);
		chk(pc.clock_source, SRC_VCO_MIN);
		rdm(SA, 32'h00000073, 32'h00000003);
		wrr(SA, 32'h00000001);
		rdm(SA, 32'h00000001, 32'h00000000);
		pulse(4'h1);
		watch(3);
		rdm(SA, 32'h00000070, 32'h00000010);
		pulse(4'h8);
		watch(10);
		chk(seen_rs, 1'b1);
		rdm(SA, 32'h00000072, 32'h00000002);
		chk(pc.clock_source, SRC_VCO_MIN);
		$display("t_fb_wake done");
	endtask
	task automatic t_pseudo();
		wrr(CA, 32'h00000033);
		pulse(4'h2);
		watch(8);
		rdm(SA, 32'h00000072, 32'h00000062);
		chk(pc.pll_enable, 1'b1);
		chk(pc.regulator_low_power, 1'b0);
		chk(pc.oscillator_enable, 1'b1);
		chk(pc.periodic_timer_run, 1'b1);
		chk(pc.watchdog_run, 1'b0);
		pulse(4'h4);
		watch(4);
		chk(seen_cw, 1'b1);
		$display("t_pseudo done");
	endtask
	// The clock returns just as full stop begins; only the exit may restart the window.
	task automatic t_full_fb();
		int n;
		wrr(CA, 32'h00000003);
		regain();
		pulse(4'h2);
		watch(21000);
		rdm(SA, 32'h00000072, 32'h00000062);
		pulse(4'h4);
		fb_wait(n);
		chk(n >= 20470 && n <= 20560, 1'b1);
		$display("t_full_fb done");
	endtask
	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Main sequence after six cycles of reset.
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_mon_off();
		t_mon_rst();
		t_masked();
		t_stop();
		t_fb_wake();
		t_pseudo();
		t_full_fb();
		finish_test();
	end
	// The run needs about 62000 cycles; the limit leaves a wide margin.
	initial begin
		#(90000 * 4);
		error_cnt++;
		finish_test();
	end
endmodule

//--- lp_core_model.sv
// ----
// Processor core model
// ----
module lp_core_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [3:0] cmd,
	input wire logic core_wake,
	input wire logic reset_seq_start,
	input wire logic monitor_reset,
	output logic core_wait_req,
	output logic core_stop_req,
	output logic wake_irq,
	output logic ext_reset_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wait_r, stop_r, wake_r, exit_now;
	logic [2:0] rst_cnt_r;
	// Masking at once avoids re-entering a low-power state on the edge after an exit.
	assign exit_now = core_wake | reset_seq_start | monitor_reset;
	assign core_wait_req = wait_r & ~exit_now;
	assign core_stop_req = stop_r & ~exit_now;
	assign wake_irq = wake_r & ~exit_now;
	assign ext_reset_pin = rst_cnt_r != 3'h0;
	// Requests are levels held until the block lets the core run again.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_r <= 1'b0;
			stop_r <= 1'b0;
			wake_r <= 1'b0;
			rst_cnt_r <= 3'h0;
		end else begin
			wait_r <= (wait_r | cmd[0]) & ~exit_now;
			stop_r <= (stop_r | cmd[1]) & ~exit_now;
			wake_r <= (wake_r | cmd[2]) & ~exit_now;
			rst_cnt_r <= cmd[3] ? 3'h4 : ((rst_cnt_r != 3'h0) ? rst_cnt_r - 3'h1 : 3'h0);
		end
	end
endmodule

//--- lp_defines.svh
`ifndef LP_DEFINES_SVH
`define LP_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define LP_CTRL_OFS 32'h0000_0000
`define LP_STATUS_OFS 32'h0000_0004
`define LP_ADDR_MSB 11

// ----------------------------------------------------------------------------
// Control word width and reset value, status bit positions
// ----------------------------------------------------------------------------
`define LP_CTRL_W 8
`define LP_CTRL_RESET 8'h03
`define LP_FLAG_BIT 0
`define LP_ST_SCM_BIT 1
`define LP_ST_GOOD_BIT 2
`define LP_ST_STATE_LSB 4

// ----------------------------------------------------------------------------
// Clock quality check and synchroniser
// ----------------------------------------------------------------------------
`define LP_QC_OSC_CYCLES 4096
`define LP_QC_CNT_W 13
`define LP_QC_LAST 13'h0FFF
`define LP_SYNC_W 3

`endif

//--- lp_pkg.sv
package lp_pkg;

	// Sequencer states.
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_WAIT = 3'b001,
		ST_STOP_SEL = 3'b010,
		ST_STOP_PLL = 3'b011,
		ST_STOP_CORE = 3'b100,
		ST_STOP_SYS = 3'b101,
		ST_STOP = 3'b110
	} lp_state_e;

	// System clock source selection.
	typedef enum logic [1:0] {
		SRC_OSC = 2'b00,
		SRC_PLL = 2'b01,
		SRC_VCO_MIN = 2'b10
	} clk_src_e;

	// Software control word, bit 7 first.
	typedef struct packed {
		logic pll_clock_select;
		logic watchdog_keep_running;
		logic timer_keep_running;
		logic pseudo_stop_select;
		logic pll_off_in_wait;
		logic self_clock_interrupt_enable;
		logic self_clock_fallback_enable;
		logic clock_monitor_enable;
	} ctrl_s;

	// Power and clock controls driven to the rest of the chip.
	typedef struct packed {
		clk_src_e clock_source;
		logic pll_enable;
		logic core_clock_enable;
		logic system_clock_enable;
		logic oscillator_enable;
		logic regulator_low_power;
		logic counters_freeze;
		logic periodic_timer_run;
		logic watchdog_run;
	} power_ctl_s;

endpackage

//--- lp_quality_check.sv
`include "lp_defines.svh"
module lp_quality_check import lp_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic osc_edge,
	input wire logic monitor_fail,
	input wire logic run,
	input wire logic restart,
	output logic clock_good
);

	// ------------------------------------------------------------------------
	// Oscillator edge counter
	// ------------------------------------------------------------------------
	logic [`LP_QC_CNT_W-1:0] cnt_r;
	logic [`LP_QC_CNT_W-1:0] cnt_nxt;
	logic good_nxt;

	// Any failure or abort discards the window, so a check always spans a full count.
	always_comb begin
		cnt_nxt = cnt_r;
		good_nxt = 1'b0;
		if (!run || monitor_fail || restart) begin
			cnt_nxt = '0;
		end else if (osc_edge) begin
			if (cnt_r == `LP_QC_LAST) begin
				good_nxt = 1'b1;
				cnt_nxt = '0;
			end else begin
				cnt_nxt = cnt_r + 13'h0001;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= '0;
			clock_good <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			clock_good <= good_nxt;
		end
	end

endmodule

//--- lp_sync2.sv
`include "lp_defines.svh"
module lp_sync2 import lp_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [`LP_SYNC_W-1:0] async_in,
	output logic [`LP_SYNC_W-1:0] sync_out
);

	// ------------------------------------------------------------------------
	// Two-flop synchroniser per bit
	// ------------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < `LP_SYNC_W; i++) begin : g_bit
			logic meta_r;
			logic meta_nxt;
			logic out_nxt;
			// The first flop feeds only the second one, never any logic.
			always_comb begin
				meta_nxt = async_in[i];
				out_nxt = meta_r;
			end
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					meta_r <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					meta_r <= meta_nxt;
					sync_out[i] <= out_nxt;
				end
			end
		end
	endgenerate

endmodule
